//--- rtl/scrseq_defs.svh
// Register offsets, reset values and timing counts of the scratch and delay bank
`ifndef SCRSEQ_DEFS_SVH
`define SCRSEQ_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCRSEQ_OFS_SCRATCH_THREE 8'hCB
`define SCRSEQ_OFS_SCRATCH_FOUR  8'hCC
`define SCRSEQ_OFS_DELAY_ONE     8'hCD
`define SCRSEQ_OFS_DELAY_TWO     8'hCE
`define SCRSEQ_OFS_DELAY_THREE   8'hCF
`define SCRSEQ_OFS_DELAY_FOUR    8'hD0
`define SCRSEQ_OFS_DELAY_UNIT    8'hD1
`define SCRSEQ_OFS_SEQ_STATUS    8'hD2

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define SCRSEQ_RST_BYTE          8'h00
`define SCRSEQ_RST_UNIT          2'h0
`define SCRSEQ_UNIT_MSB          1
`define SCRSEQ_STAT_BUSY_BIT     0

// ----------------------------------------
// Delay step sizes in microseconds and clock rate in MHz
// ----------------------------------------
`define SCRSEQ_STEP0_US          1
`define SCRSEQ_STEP1_US          10
`define SCRSEQ_STEP2_US          100
`define SCRSEQ_STEP3_US          1000
`define SCRSEQ_CLK_MHZ           100

`endif

//--- rtl/scrseq_delay_timer.sv
// Timer that waits a delay count times a step length
`timescale 1ns/10ps
`include "scrseq_defs.svh"

module scrseq_delay_timer #(
  parameter int STEP_W = 24
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Request
  input  wire logic              start_in,
  input  wire logic [7:0]        count_in,
  input  wire logic [STEP_W-1:0] step_cycles_in,
  // Status
  output logic                   busy_out,
  output logic                   done_out
);

  scrseq_pkg::scrseq_state_e state;
  logic [7:0]                steps_left;
  logic [STEP_W-1:0]         cyc_left;

  if (STEP_W < 2) begin : g_step_w_check
    $error("STEP_W too small");
  end

  // ----------------------------------------
  // Count steps then cycles in each step
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state      <= scrseq_pkg::SCRSEQ_IDLE;
      steps_left <= 8'h00;
      cyc_left   <= '0;
    end else begin
      case (state)
        scrseq_pkg::SCRSEQ_IDLE: begin
          if (start_in) begin
            steps_left <= count_in;
            cyc_left   <= step_cycles_in;
            state      <= (count_in == 8'h00) ? scrseq_pkg::SCRSEQ_DONE
                                              : scrseq_pkg::SCRSEQ_RUN;
          end
        end
        scrseq_pkg::SCRSEQ_RUN: begin // see R7
          if (cyc_left > STEP_W'(1)) begin
            cyc_left <= cyc_left - STEP_W'(1);
          end else if (steps_left > 8'h01) begin
            steps_left <= steps_left - 8'h01;
            cyc_left   <= step_cycles_in; // see R5
          end else begin
            state <= scrseq_pkg::SCRSEQ_DONE;
          end
        end
        scrseq_pkg::SCRSEQ_DONE: begin
          state <= scrseq_pkg::SCRSEQ_IDLE;
        end
        default: begin
          state <= scrseq_pkg::SCRSEQ_IDLE;
        end
      endcase
    end
  end

  assign busy_out = (state == scrseq_pkg::SCRSEQ_RUN);
  assign done_out = (state == scrseq_pkg::SCRSEQ_DONE);

endmodule : scrseq_delay_timer

//--- rtl/scrseq_pkg.sv
// Types of the scratch and delay bank
package scrseq_pkg;

  // ----------------------------------------
  // Delay timer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SCRSEQ_IDLE = 2'h0,
    SCRSEQ_RUN  = 2'h1,
    SCRSEQ_DONE = 2'h3
  } scrseq_state_e;

endpackage : scrseq_pkg

//--- rtl/scrseq_regs.sv
// Scratchpad and sequencer delay register bank
`timescale 1ns/10ps
`include "scrseq_defs.svh"

// What this block does
// R1 - Scratch bytes are plain read/write storage, read back as written.
// R2 - Scratch bytes clear to zero when the internal regulator turns off.
// R3 - Scratch bytes hold while regulator on, lost in low-power standby.
// R4 - Four read/write delay bytes at consecutive addresses for the sequencer.
// R5 - Delay unit comes from the separate step-size setting.
// R6 - Delay bytes load defaults from nonvolatile config memory at init.
// R7 - Sequencer delay waits value times step size before next step.
module scrseq_regs #(
  parameter int STEP_W = 24
) (
  // Clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        SYS_RST_IN,
  // Register port
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  // Power state
  input  wire logic        INTERNAL_REGULATOR_ON_IN,
  // Nonvolatile defaults
  input  wire logic        NVM_LOAD_IN,
  input  wire logic [31:0] NVM_DELAYS_IN,
  // Sequencer delay request
  input  wire logic        SEQ_DELAY_START_IN,
  input  wire logic [1:0]  SEQ_DELAY_SEL_IN,
  output logic             SEQ_DELAY_BUSY_OUT,
  output logic             SEQ_DELAY_DONE_OUT,
  // Delay values to the sequencer
  output logic      [31:0] SEQ_DELAYS_OUT
);

  localparam int STEP3_CYC = `SCRSEQ_STEP3_US * `SCRSEQ_CLK_MHZ;

  logic [7:0]        scratch_byte_three_field;
  logic [7:0]        scratch_byte_four_field;
  logic [7:0]        seq_delay [4];
  logic [1:0]        seq_delay_unit;
  logic [STEP_W-1:0] step_cycles;
  logic              busy;

  if (STEP_W < $clog2(STEP3_CYC + 1)) begin : g_step_w_check
    $error("STEP_W cannot hold longest step");
  end

  // ----------------------------------------
  // Scratch bytes
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      scratch_byte_three_field <= `SCRSEQ_RST_BYTE;
      scratch_byte_four_field  <= `SCRSEQ_RST_BYTE;
    end else if (!INTERNAL_REGULATOR_ON_IN) begin // see R2 see R3
      scratch_byte_three_field <= `SCRSEQ_RST_BYTE;
      scratch_byte_four_field  <= `SCRSEQ_RST_BYTE;
    end else if (WR_IN) begin // see R1
      if (ADDR_IN == `SCRSEQ_OFS_SCRATCH_THREE) begin
        scratch_byte_three_field <= WDATA_IN;
      end
      if (ADDR_IN == `SCRSEQ_OFS_SCRATCH_FOUR) begin
        scratch_byte_four_field <= WDATA_IN;
      end
    end
  end

  // ----------------------------------------
  // Delay bytes
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      for (int i = 0; i < 4; i++) begin
        seq_delay[i] <= `SCRSEQ_RST_BYTE;
      end
    end else if (NVM_LOAD_IN) begin // see R6
      for (int i = 0; i < 4; i++) begin
        seq_delay[i] <= NVM_DELAYS_IN[8*i +: 8];
      end
    end else if (WR_IN) begin // see R4
      for (int i = 0; i < 4; i++) begin
        if (ADDR_IN == `SCRSEQ_OFS_DELAY_ONE + 8'(i)) begin
          seq_delay[i] <= WDATA_IN;
        end
      end
    end
  end

  // ----------------------------------------
  // Delay step size
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      seq_delay_unit <= `SCRSEQ_RST_UNIT;
    end else if (WR_IN && ADDR_IN == `SCRSEQ_OFS_DELAY_UNIT) begin
      seq_delay_unit <= WDATA_IN[`SCRSEQ_UNIT_MSB:0];
    end
  end

  always_comb begin
    case (seq_delay_unit) // see R5
      2'h0:    step_cycles = STEP_W'(`SCRSEQ_STEP0_US * `SCRSEQ_CLK_MHZ);
      2'h1:    step_cycles = STEP_W'(`SCRSEQ_STEP1_US * `SCRSEQ_CLK_MHZ);
      2'h2:    step_cycles = STEP_W'(`SCRSEQ_STEP2_US * `SCRSEQ_CLK_MHZ);
      default: step_cycles = STEP_W'(STEP3_CYC);
    endcase
  end

  // ----------------------------------------
  // Delay timer
  // ----------------------------------------
  scrseq_delay_timer #(
    .STEP_W (STEP_W)
  ) u_timer (
    .clk_in         (REF_CLK_IN),
    .rst_in         (SYS_RST_IN),
    .start_in       (SEQ_DELAY_START_IN),
    .count_in       (seq_delay[SEQ_DELAY_SEL_IN]), // see R7
    .step_cycles_in (step_cycles),
    .busy_out       (busy),
    .done_out       (SEQ_DELAY_DONE_OUT)
  );

  assign SEQ_DELAY_BUSY_OUT = busy;
  assign SEQ_DELAYS_OUT = {seq_delay[3], seq_delay[2], seq_delay[1], seq_delay[0]};

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `SCRSEQ_OFS_SCRATCH_THREE: RDATA_OUT <= scratch_byte_three_field; // see R1
        `SCRSEQ_OFS_SCRATCH_FOUR:  RDATA_OUT <= scratch_byte_four_field;
        `SCRSEQ_OFS_DELAY_ONE:     RDATA_OUT <= seq_delay[0];
        `SCRSEQ_OFS_DELAY_TWO:     RDATA_OUT <= seq_delay[1];
        `SCRSEQ_OFS_DELAY_THREE:   RDATA_OUT <= seq_delay[2];
        `SCRSEQ_OFS_DELAY_FOUR:    RDATA_OUT <= seq_delay[3];
        `SCRSEQ_OFS_DELAY_UNIT:    RDATA_OUT <= {6'h00, seq_delay_unit};
        `SCRSEQ_OFS_SEQ_STATUS:    RDATA_OUT <= {7'h00, busy};
        default:                   RDATA_OUT <= 8'h00;
      endcase
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end

endmodule : scrseq_regs

//--- testbench/scrseq_regs_sva.sv
// Assertions of the scratch and delay bank
`timescale 1ns/10ps
`include "scrseq_defs.svh"
module scrseq_regs_sva (
  // Clock, reset and register port
  input wire logic        REF_CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [7:0]  WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [7:0]  RDATA_OUT,
  // Power, defaults and delay
  input wire logic        INTERNAL_REGULATOR_ON_IN,
  input wire logic        NVM_LOAD_IN,
  input wire logic [31:0] NVM_DELAYS_IN,
  input wire logic        SEQ_DELAY_START_IN,
  input wire logic [1:0]  SEQ_DELAY_SEL_IN,
  input wire logic        SEQ_DELAY_BUSY_OUT,
  input wire logic        SEQ_DELAY_DONE_OUT,
  input wire logic [31:0] SEQ_DELAYS_OUT
);
  logic [1:0] unit;
  logic       go;
  assign go = SEQ_DELAY_START_IN && !SEQ_DELAY_BUSY_OUT && !SEQ_DELAY_DONE_OUT;
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) unit <= 2'h0;
    else if (WR_IN && ADDR_IN == `SCRSEQ_OFS_DELAY_UNIT) unit <= WDATA_IN[1:0];
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_rdata_idle_zero: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data not zero outside read");
  a_scratch_read_back: assert property (
    (WR_IN && ADDR_IN == 8'hCC && INTERNAL_REGULATOR_ON_IN)
    ##1 (RD_IN && ADDR_IN == 8'hCC && INTERNAL_REGULATOR_ON_IN)
    |=> RDATA_OUT == $past(WDATA_IN, 2)) else $error("scratch read back wrong");
  a_scratch_cleared: assert property (
    !INTERNAL_REGULATOR_ON_IN ##1 (RD_IN && ADDR_IN == 8'hCC)
    |=> RDATA_OUT == 8'h00) else $error("scratch kept with regulator off");
  a_delay_write: assert property (
    WR_IN && ADDR_IN == 8'hCD && !NVM_LOAD_IN
    |=> SEQ_DELAYS_OUT[7:0] == $past(WDATA_IN)) else $error("delay write lost");
  a_nvm_default: assert property (
    NVM_LOAD_IN |=> SEQ_DELAYS_OUT == $past(NVM_DELAYS_IN))
    else $error("defaults not loaded");
  a_zero_delay: assert property (
    go && SEQ_DELAYS_OUT[8*SEQ_DELAY_SEL_IN +: 8] == 8'h00
    |=> SEQ_DELAY_DONE_OUT && !SEQ_DELAY_BUSY_OUT) else $error("zero delay wrong");
  a_one_step_time: assert property (
    go && SEQ_DELAY_SEL_IN == 2'h0 && unit == 2'h0
    && SEQ_DELAYS_OUT[7:0] == 8'h01 |-> ##101 SEQ_DELAY_DONE_OUT)
    else $error("delay length wrong");
  a_done_after_busy: assert property (
    $fell(SEQ_DELAY_BUSY_OUT) |-> SEQ_DELAY_DONE_OUT)
    else $error("busy ended without done");
endmodule : scrseq_regs_sva
bind scrseq_regs scrseq_regs_sva chk_u (.REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .INTERNAL_REGULATOR_ON_IN(INTERNAL_REGULATOR_ON_IN), .NVM_LOAD_IN(NVM_LOAD_IN),
  .NVM_DELAYS_IN(NVM_DELAYS_IN), .SEQ_DELAY_START_IN(SEQ_DELAY_START_IN),
  .SEQ_DELAY_SEL_IN(SEQ_DELAY_SEL_IN), .SEQ_DELAY_BUSY_OUT(SEQ_DELAY_BUSY_OUT),
  .SEQ_DELAY_DONE_OUT(SEQ_DELAY_DONE_OUT), .SEQ_DELAYS_OUT(SEQ_DELAYS_OUT));

//--- testbench/tb_top.sv
// Testbench of the scratch and delay bank
`timescale 1ns/10ps
`include "scrseq_defs.svh"
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        reg_on = 1'b1, ld = 1'b0, start = 1'b0, busy, done;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0]  sel = 2'h0;
  logic [31:0] nonvolatile_config_memory = 32'h0, delays;
  int          fails = 0, num_checks = 0;
  always #5 clk = ~clk;
  scrseq_regs dut_u (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .INTERNAL_REGULATOR_ON_IN(reg_on),
    .NVM_LOAD_IN(ld), .NVM_DELAYS_IN(nonvolatile_config_memory), .SEQ_DELAY_START_IN(start), .SEQ_DELAY_SEL_IN(sel),
    .SEQ_DELAY_BUSY_OUT(busy), .SEQ_DELAY_DONE_OUT(done), .SEQ_DELAYS_OUT(delays));
  // ----
  // Shared tasks
  // ----
  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(32'(rdata), 32'(e));
    @(posedge clk);
  endtask : rd_reg
  task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(32'(rdata), 32'(d));
    @(posedge clk);
  endtask : wr_rd_reg
  task automatic run_delay(input logic [1:0] s, input int exp_n, input int exp_b);
    int n = 0;
    int b = 0;
    sel <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1) begin
      @(negedge clk);
      n++;
      if (busy === 1'b1) b++;
      if (n > 12000) begin
        fails++;
        complete_run();
      end
    end
    chk(n, exp_n);
    chk(b, exp_b);
    @(posedge clk);
  endtask : run_delay
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    for (int a = 8'hCB; a <= 8'hD0; a++) rd_reg(8'(a), 8'h00);
    rd_reg(8'h40, 8'h00);
  endtask : t_reset
  task automatic t_scratch();
    wr_reg(8'hCB, 8'hA5);
    wr_reg(8'hCC, 8'h5A);
    repeat (20) @(posedge clk);
    rd_reg(8'hCB, 8'hA5);
    rd_reg(8'hCC, 8'h5A);
    wr_rd_reg(8'hCC, 8'hC3);
  endtask : t_scratch
  task automatic t_regulator();
    reg_on <= 1'b0;
    wr_reg(8'hCC, 8'h33);
    reg_on <= 1'b1;
    rd_reg(8'hCC, 8'h00);
    rd_reg(8'hCB, 8'h00);
  endtask : t_regulator
  task automatic t_delay_regs();
    for (int i = 0; i < 4; i++) wr_reg(8'(8'hCD + i), 8'(8'h3C + 8'h11 * i));
    for (int i = 0; i < 4; i++) rd_reg(8'(8'hCD + i), 8'(8'h3C + 8'h11 * i));
    chk(delays, 32'h6F5E4D3C);
  endtask : t_delay_regs
  task automatic t_nvm();
    nonvolatile_config_memory <= 32'h44332211;
    ld <= 1'b1;
    wr_reg(8'hD0, 8'hFF);
    ld <= 1'b0;
    chk(delays, 32'h44332211);
    rd_reg(8'hD0, 8'h44);
  endtask : t_nvm
  task automatic t_timing();
    wr_reg(8'hCD, 8'h01);
    wr_reg(8'hCE, 8'h00);
    run_delay(2'h0, 101, 100);
    run_delay(2'h1, 1, 0);
    wr_reg(`SCRSEQ_OFS_DELAY_UNIT, 8'h01);
    wr_reg(8'hCD, 8'h02);
    run_delay(2'h0, 2001, 2000);
  endtask : t_timing
  task automatic t_step_units();
    wr_reg(`SCRSEQ_OFS_DELAY_UNIT, 8'h02);
    wr_reg(8'hCD, 8'h01);
    run_delay(2'h0, 10001, 10000);
    wr_reg(`SCRSEQ_OFS_DELAY_UNIT, 8'h03);
    rd_reg(`SCRSEQ_OFS_DELAY_UNIT, 8'h03);
    sel <= 2'h0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rd_reg(`SCRSEQ_OFS_SEQ_STATUS, 8'h01);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'(busy), 32'h0);
    chk(32'(rdata), 32'h0);
    @(posedge clk);
    rd_reg(`SCRSEQ_OFS_DELAY_UNIT, 8'h00);
    rd_reg(`SCRSEQ_OFS_SEQ_STATUS, 8'h00);
    rd_reg(8'hCD, 8'h00);
  endtask : t_step_units
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_scratch();
    t_regulator();
    t_delay_regs();
    t_nvm();
    t_timing();
    t_step_units();
    complete_run();
  end
endmodule : tb_top
